// ### wtg_pkg.sv
// constants and types of the wake-up and general purpose timer block
package wtg_pkg;

	// system clock and derived tick rates
	localparam int          CLOCK_HZ        = 100_000_000;
	localparam int          RC_OSC_HZ       = 32_768;
	localparam int          FAST_TIMER_HZ   = 2_000_000;
	localparam logic [11:0] RC_TICK_CYCLES  = 12'(CLOCK_HZ / RC_OSC_HZ);
	localparam logic [5:0]  FAST_TICK_CYCLES = 6'(CLOCK_HZ / FAST_TIMER_HZ);

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FINISH_ACTIONS   = 8'h0a;
	localparam logic [7:0] IDX_SERIAL_PORT      = 8'h0c;
	localparam logic [7:0] IDX_SLEEP_WAKE       = 8'h2d;
	localparam logic [7:0] IDX_WAKE_DIVIDERS    = 8'h2e;
	localparam logic [7:0] IDX_WAKE_INTERVAL_HI = 8'h2f;
	localparam logic [7:0] IDX_WAKE_INTERVAL_LO = 8'h30;
	localparam logic [7:0] IDX_WINDOW_LENGTH    = 8'h31;
	localparam logic [7:0] IDX_GP_SOURCE        = 8'h32;
	localparam logic [7:0] IDX_GP_DIVIDER       = 8'h33;
	localparam logic [7:0] IDX_GP_ONE_INTERVAL  = 8'h34;
	localparam logic [7:0] IDX_GP_TWO_INTERVAL  = 8'h35;
	localparam logic [7:0] IDX_CHANNEL_CHECK    = 8'h39;
	localparam logic [7:0] IDX_TIMER_STATUS     = 8'h3a;

	// sleep_wake_control fields
	localparam int SW_SLEEP_BIT       = 0;
	localparam int SW_CLOCK_ORIGIN    = 2;
	localparam int SW_WAKE_TIMER_EN   = 4;
	localparam int SW_WINDOW_EN       = 5;
	localparam int SW_WAKE_TARGET     = 6;
	localparam int SW_SINGLE_WAKE     = 7;

	// other fields
	localparam int FA_RECEIVE_LSB     = 2;
	localparam int FA_TRANSMIT_LSB    = 0;
	localparam int SP_RECEIVE_OUT_LSB = 6;
	localparam int CC_QUICK_CHECK     = 3;
	localparam int GP_ONE_RUN         = 0;
	localparam int GP_ONE_ORIGIN      = 1;
	localparam int GP_TWO_RUN         = 4;
	localparam int GP_TWO_ORIGIN      = 5;

	// field codes
	localparam logic [1:0] FINISH_TO_SLEEP  = 2'h3;
	localparam logic [1:0] FINISH_TO_RX     = 2'h1;
	localparam logic [1:0] FINISH_TO_TX     = 2'h2;
	localparam logic [1:0] SERIAL_OUT_CONT  = 2'h1;

	localparam logic [7:0] REG_RESET = 8'h00;

	typedef enum logic [1:0] {
		RS_OFF,
		RS_RX,
		RS_TX,
		RS_SLEEP
	} wtg_radio_state_t;

endpackage

// ### wtg_timers.sv
// wake-up, active window and general purpose timers with apb registers
`timescale 1ns/1ps

//
// Overview of operation
// RULE_01: wake timer expiry leaves sleep to target
// RULE_02: single wake bit picks interval or once
// RULE_03: window expiry before sync returns rx to sleep
// RULE_04: after sync stay in receive until sleep
// RULE_05: window expiry forces transmit back to sleep
// RULE_06: software sizes window past transmission end
// RULE_07: clock origin bit picks pin or rc
// RULE_08: wake period is clock times divider times interval
// RULE_09: window is clock times divider times length-1
// RULE_10: software keeps interval>=2 and length>=1
// RULE_11: software sets both divider nibbles equal
// RULE_12: continuous serial output: no sync, window sleeps
// RULE_13: receive done follows receive finish action
// RULE_14: transmit done follows transmit finish action
// RULE_15: single wake stays awake; sleep command rearms
// RULE_16: quick check idle sleeps, carrier stays
// RULE_17: single wake idle channel sleeps and rechecks
// RULE_18: two independent gp timers each raise pulse
// RULE_19: gp period is clock times divider times interval
// RULE_20: gp source bit picks wake clock or 2mhz
// RULE_21: counters reload settings at each period start
module wtg_timers (
	input  wire logic                      clock,
	input  wire logic                      arst_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [9:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      externalSlowClockPin,
	input  wire logic                      syncWordDetected,
	input  wire logic                      receiveDone,
	input  wire logic                      transmitDone,
	input  wire logic                      carrierCheckDone,
	input  wire logic                      carrierFound,
	output wtg_pkg::wtg_radio_state_t      radioState,
	output logic                           carrierCheckStart,
	output logic                           gpTimerOneIrq,
	output logic                           gpTimerTwoIrq
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		wtg_pkg::wtg_radio_state_t state;
		logic [7:0]        sleepWake;
		logic [7:0]        dividers;
		logic [7:0]        intervalHi;
		logic [7:0]        intervalLo;
		logic [7:0]        windowLength;
		logic [7:0]        gpSource;
		logic [7:0]        gpDivider;
		logic [1:0][7:0]   gpInterval;
		logic [7:0]        finishActions;
		logic [7:0]        serialPort;
		logic [7:0]        channelCheck;
		logic [3:0]        wakePre;
		logic [15:0]       wakeCnt;
		logic [3:0]        windowPre;
		logic [7:0]        windowCnt;
		logic              windowOn;
		logic              timedWake;
		logic              syncSeen;
		logic              checkPending;
		logic              armed;
		logic              extPrev;
		logic [11:0]       rcCnt;
		logic [5:0]        fastCnt;
		logic [1:0][7:0]   gpPre;
		logic [1:0][7:0]   gpCnt;
		logic [1:0]        gpIrq;
		logic              checkStart;
		logic [31:0]       rdata;
		logic              ready;
		logic              slverr;
	} wtg_state_t;

	wtg_state_t st_reg;
	wtg_state_t st_next;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [7:0]  idx;
		logic        access;
		logic        hit;
		logic [7:0]  rd;
		logic        wrNow;
		logic        extTick;
		logic        rcTick;
		logic        fastTick;
		logic        wakeTick;
		logic        srcTick;
		logic        wakeExpire;
		logic        windowExpire;
		logic        toSleep;
		logic        sleepCmd;
		logic        wakeCmd;
		logic [1:0]  rxAct;
		logic [1:0]  txAct;
		idx          = paddr[9:2];
		access       = psel & penable;
		hit          = 1'b1;
		rd           = 8'h00;
		wrNow        = 1'b0;
		extTick      = 1'b0;
		rcTick       = 1'b0;
		fastTick     = 1'b0;
		wakeTick     = 1'b0;
		srcTick      = 1'b0;
		wakeExpire   = 1'b0;
		windowExpire = 1'b0;
		toSleep      = 1'b0;
		sleepCmd     = 1'b0;
		wakeCmd      = 1'b0;
		rxAct        = st_reg.finishActions[wtg_pkg::FA_RECEIVE_LSB +: 2];
		txAct        = st_reg.finishActions[wtg_pkg::FA_TRANSMIT_LSB +: 2];
		st_next            = st_reg;
		st_next.gpIrq      = 2'h0;
		st_next.checkStart = 1'b0;

		// tick sources
		extTick = externalSlowClockPin & ~st_reg.extPrev;
		st_next.extPrev = externalSlowClockPin;
		if (st_reg.rcCnt == wtg_pkg::RC_TICK_CYCLES - 12'h001) begin
			st_next.rcCnt = 12'h000;
			rcTick = 1'b1;
		end else begin
			st_next.rcCnt = st_reg.rcCnt + 12'h001;
		end
		if (st_reg.fastCnt == wtg_pkg::FAST_TICK_CYCLES - 6'h01) begin
			st_next.fastCnt = 6'h00;
			fastTick = 1'b1;
		end else begin
			st_next.fastCnt = st_reg.fastCnt + 6'h01;
		end
		wakeTick = st_reg.sleepWake[wtg_pkg::SW_CLOCK_ORIGIN] ? extTick
			: rcTick; // RULE_07

		// apb: one wait cycle, answer on second access cycle
		unique case (idx)
			wtg_pkg::IDX_FINISH_ACTIONS:   rd = st_reg.finishActions;
			wtg_pkg::IDX_SERIAL_PORT:      rd = st_reg.serialPort;
			wtg_pkg::IDX_SLEEP_WAKE:       rd = st_reg.sleepWake;
			wtg_pkg::IDX_WAKE_DIVIDERS:    rd = st_reg.dividers;
			wtg_pkg::IDX_WAKE_INTERVAL_HI: rd = st_reg.intervalHi;
			wtg_pkg::IDX_WAKE_INTERVAL_LO: rd = st_reg.intervalLo;
			wtg_pkg::IDX_WINDOW_LENGTH:    rd = st_reg.windowLength;
			wtg_pkg::IDX_GP_SOURCE:        rd = st_reg.gpSource;
			wtg_pkg::IDX_GP_DIVIDER:       rd = st_reg.gpDivider;
			wtg_pkg::IDX_GP_ONE_INTERVAL:  rd = st_reg.gpInterval[0];
			wtg_pkg::IDX_GP_TWO_INTERVAL:  rd = st_reg.gpInterval[1];
			wtg_pkg::IDX_CHANNEL_CHECK:    rd = st_reg.channelCheck;
			wtg_pkg::IDX_TIMER_STATUS:
				rd = {st_reg.timedWake, st_reg.syncSeen, st_reg.windowOn,
					st_reg.armed, st_reg.checkPending, 1'b0, st_reg.state};
			default:                       hit = 1'b0;
		endcase
		if (access & ~st_reg.ready) begin
			st_next.ready  = 1'b1;
			st_next.slverr = ~hit;
			st_next.rdata  = {24'h000000, rd};
		end else begin
			st_next.ready  = 1'b0;
			st_next.slverr = 1'b0;
		end
		wrNow = access & st_reg.ready & pwrite & hit;
		if (wrNow) begin
			unique case (idx)
				wtg_pkg::IDX_FINISH_ACTIONS:
					st_next.finishActions = pwdata[7:0];
				wtg_pkg::IDX_SERIAL_PORT:
					st_next.serialPort = pwdata[7:0];
				wtg_pkg::IDX_SLEEP_WAKE: begin
					st_next.sleepWake = pwdata[7:0];
					sleepCmd = pwdata[wtg_pkg::SW_SLEEP_BIT];
					wakeCmd  = ~pwdata[wtg_pkg::SW_SLEEP_BIT]
						& (st_reg.state == wtg_pkg::RS_SLEEP);
				end
				wtg_pkg::IDX_WAKE_DIVIDERS:
					st_next.dividers = pwdata[7:0];
				wtg_pkg::IDX_WAKE_INTERVAL_HI:
					st_next.intervalHi = pwdata[7:0];
				wtg_pkg::IDX_WAKE_INTERVAL_LO:
					st_next.intervalLo = pwdata[7:0];
				wtg_pkg::IDX_WINDOW_LENGTH:
					st_next.windowLength = pwdata[7:0];
				wtg_pkg::IDX_GP_SOURCE:
					st_next.gpSource = pwdata[7:0];
				wtg_pkg::IDX_GP_DIVIDER:
					st_next.gpDivider = pwdata[7:0];
				wtg_pkg::IDX_GP_ONE_INTERVAL:
					st_next.gpInterval[0] = pwdata[7:0];
				wtg_pkg::IDX_GP_TWO_INTERVAL:
					st_next.gpInterval[1] = pwdata[7:0];
				wtg_pkg::IDX_CHANNEL_CHECK:
					st_next.channelCheck = pwdata[7:0];
				default: ;
			endcase
		end

		// active window: prescale by high nibble, count length-1
		if (st_reg.windowOn & wakeTick) begin
			if (st_reg.windowPre <= 4'h1) begin
				st_next.windowPre = st_reg.dividers[7:4]; // RULE_21
				if (st_reg.windowCnt <= 8'h01) begin
					windowExpire = 1'b1; // RULE_09
				end else begin
					st_next.windowCnt = st_reg.windowCnt - 8'h01;
				end
			end else begin
				st_next.windowPre = st_reg.windowPre - 4'h1;
			end
		end

		// radio state sequencing
		unique case (st_reg.state)
			wtg_pkg::RS_SLEEP: begin
				if (st_reg.sleepWake[wtg_pkg::SW_WAKE_TIMER_EN] & wakeTick
					& (~st_reg.sleepWake[wtg_pkg::SW_SINGLE_WAKE]
					| st_reg.armed)) begin // RULE_02
					if (st_reg.wakePre <= 4'h1) begin
						st_next.wakePre = st_reg.dividers[3:0]; // RULE_21
						if (st_reg.wakeCnt <= 16'h0001) begin
							wakeExpire = 1'b1; // RULE_08
						end else begin
							st_next.wakeCnt = st_reg.wakeCnt - 16'h0001;
						end
					end else begin
						st_next.wakePre = st_reg.wakePre - 4'h1;
					end
				end
				if (wakeExpire) begin
					st_next.state = st_reg.sleepWake[wtg_pkg::SW_WAKE_TARGET]
						? wtg_pkg::RS_TX : wtg_pkg::RS_RX; // RULE_01
					st_next.timedWake = 1'b1;
					st_next.armed     = 1'b0; // RULE_15
					st_next.syncSeen  = 1'b0;
					// window only in interval mode
					st_next.windowOn =
						~st_reg.sleepWake[wtg_pkg::SW_SINGLE_WAKE]
						& st_reg.sleepWake[wtg_pkg::SW_WINDOW_EN]; // RULE_03
					st_next.windowPre = st_reg.dividers[7:4]; // RULE_21
					st_next.windowCnt = st_reg.windowLength - 8'h01;
					if (~st_reg.sleepWake[wtg_pkg::SW_WAKE_TARGET]
						& st_reg.channelCheck[wtg_pkg::CC_QUICK_CHECK]) begin
						st_next.checkPending = 1'b1; // RULE_16
						st_next.checkStart   = 1'b1;
					end
				end
				if (wakeCmd) begin
					st_next.state        = wtg_pkg::RS_OFF;
					st_next.windowOn     = 1'b0;
					// a wake command beats a timed wake in the same cycle
					st_next.timedWake    = 1'b0;
					st_next.checkPending = 1'b0;
					st_next.checkStart   = 1'b0;
				end
			end
			wtg_pkg::RS_RX: begin
				if (st_reg.checkPending & carrierCheckDone) begin
					st_next.checkPending = 1'b0;
					// idle channel sleeps; carrier stays to hunt sync
					toSleep = ~carrierFound; // RULE_16 RULE_17
				end
				// continuous serial output never reports sync
				if (syncWordDetected & (st_reg.serialPort
					[wtg_pkg::SP_RECEIVE_OUT_LSB +: 2]
					!= wtg_pkg::SERIAL_OUT_CONT)) begin // RULE_12
					st_next.syncSeen = 1'b1; // RULE_04
					st_next.windowOn = 1'b0;
				end
				// a sync word in the expiry cycle still keeps receive
				if (windowExpire & ~st_next.syncSeen) begin
					toSleep = 1'b1; // RULE_03
				end
				if (receiveDone) begin
					unique case (rxAct) // RULE_13
						wtg_pkg::FINISH_TO_SLEEP: toSleep = 1'b1; // RULE_04
						wtg_pkg::FINISH_TO_TX: st_next.state = wtg_pkg::RS_TX;
						wtg_pkg::FINISH_TO_RX: st_next.state = wtg_pkg::RS_RX;
						default:               st_next.state = wtg_pkg::RS_OFF;
					endcase
				end
			end
			wtg_pkg::RS_TX: begin
				// expiry cuts a frame still going out
				if (windowExpire) begin
					toSleep = 1'b1; // RULE_05
				end
				if (transmitDone) begin
					unique case (txAct) // RULE_14
						wtg_pkg::FINISH_TO_SLEEP: toSleep = 1'b1;
						wtg_pkg::FINISH_TO_TX: st_next.state = wtg_pkg::RS_TX;
						wtg_pkg::FINISH_TO_RX: st_next.state = wtg_pkg::RS_RX;
						default:               st_next.state = wtg_pkg::RS_OFF;
					endcase
				end
			end
			wtg_pkg::RS_OFF: ;
		endcase

		// sleep entry reloads the wake period and rearms single wake
		if (toSleep | sleepCmd) begin
			st_next.state        = wtg_pkg::RS_SLEEP;
			st_next.wakePre      = st_reg.dividers[3:0]; // RULE_21
			st_next.wakeCnt      = {st_reg.intervalHi, st_reg.intervalLo};
			st_next.armed        = 1'b1; // RULE_15 RULE_17
			st_next.windowOn     = 1'b0;
			st_next.timedWake    = 1'b0;
			st_next.syncSeen     = 1'b0;
			st_next.checkPending = 1'b0;
			st_next.checkStart   = 1'b0;
		end
		if (st_next.state != wtg_pkg::RS_SLEEP && st_reg.state ==
			wtg_pkg::RS_SLEEP && !wakeExpire) begin
			st_next.timedWake = 1'b0;
		end

		// general purpose timers, one loop body per channel
		for (int ch = 0; ch < 2; ch++) begin
			srcTick = st_reg.gpSource[ch == 0 ? wtg_pkg::GP_ONE_ORIGIN
				: wtg_pkg::GP_TWO_ORIGIN] ? fastTick : wakeTick; // RULE_20
			if (!st_reg.gpSource[ch == 0 ? wtg_pkg::GP_ONE_RUN
				: wtg_pkg::GP_TWO_RUN]) begin
				st_next.gpPre[ch] = st_reg.gpDivider; // RULE_21
				st_next.gpCnt[ch] = st_reg.gpInterval[ch];
			end else if (srcTick) begin
				if (st_reg.gpPre[ch] <= 8'h01) begin
					st_next.gpPre[ch] = st_reg.gpDivider;
					if (st_reg.gpCnt[ch] <= 8'h01) begin
						st_next.gpIrq[ch] = 1'b1; // RULE_18 RULE_19
						st_next.gpCnt[ch] = st_reg.gpInterval[ch]; // RULE_21
					end else begin
						st_next.gpCnt[ch] = st_reg.gpCnt[ch] - 8'h01;
					end
				end else begin
					st_next.gpPre[ch] = st_reg.gpPre[ch] - 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{
				state:         wtg_pkg::RS_OFF,
				sleepWake:     wtg_pkg::REG_RESET,
				dividers:      wtg_pkg::REG_RESET,
				intervalHi:    wtg_pkg::REG_RESET,
				intervalLo:    wtg_pkg::REG_RESET,
				windowLength:  wtg_pkg::REG_RESET,
				gpSource:      wtg_pkg::REG_RESET,
				gpDivider:     wtg_pkg::REG_RESET,
				gpInterval:    '0,
				finishActions: wtg_pkg::REG_RESET,
				serialPort:    wtg_pkg::REG_RESET,
				channelCheck:  wtg_pkg::REG_RESET,
				default:       '0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign prdata            = st_reg.rdata;
	assign pready            = st_reg.ready;
	assign pslverr           = st_reg.slverr;
	assign radioState        = st_reg.state;
	assign carrierCheckStart = st_reg.checkStart;
	assign gpTimerOneIrq     = st_reg.gpIrq[0];
	assign gpTimerTwoIrq     = st_reg.gpIrq[1];

endmodule

// ### wtg_timers_chk.sv
// assertion checker bound to the wake-up and general purpose timers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module wtg_timers_chk (
	input wire logic                      clock,
	input wire logic                      arst_n,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [9:0]                paddr,
	input wire logic [31:0]               pwdata,
	input wire logic [31:0]               prdata,
	input wire logic                      pready,
	input wire logic                      pslverr,
	input wire logic                      externalSlowClockPin,
	input wire logic                      syncWordDetected,
	input wire logic                      receiveDone,
	input wire logic                      transmitDone,
	input wire logic                      carrierCheckDone,
	input wire logic                      carrierFound,
	input wire wtg_pkg::wtg_radio_state_t radioState,
	input wire logic                      carrierCheckStart,
	input wire logic                      gpTimerOneIrq,
	input wire logic                      gpTimerTwoIrq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	pready_wait_a: assert property (psel && penable && !$past(penable)
		|-> !pready ##1 pready) else $error("pready not on second access");
	slverr_with_a: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside a completion");
	rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	irq_pulses_a: assert property ((gpTimerOneIrq |=> !gpTimerOneIrq) and
		(gpTimerTwoIrq |=> !gpTimerTwoIrq)) else $error("irq not a pulse");
	check_in_rx_a: assert property (carrierCheckStart |->
		radioState == wtg_pkg::RS_RX && !$past(carrierCheckStart))
		else $error("channel check asked outside receive");
	sync_holds_a: assert property (radioState == wtg_pkg::RS_RX &&
		syncWordDetected && !receiveDone && !transmitDone && !psel &&
		!carrierCheckDone |=> radioState == wtg_pkg::RS_RX)
		else $error("receive left at sync word");
	sleep_cmd_a: assert property (psel && penable && pready && pwrite &&
		paddr[9:2] == wtg_pkg::IDX_SLEEP_WAKE && pwdata[0]
		|=> radioState == wtg_pkg::RS_SLEEP) else $error("sleep not entered");
	// main scenarios reached
	cover property (radioState == wtg_pkg::RS_SLEEP ##1
		radioState == wtg_pkg::RS_RX);
	cover property (gpTimerTwoIrq);
	cover property (carrierCheckStart);
endmodule
bind wtg_timers wtg_timers_chk chk_u (.clock(clock), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.externalSlowClockPin(externalSlowClockPin),
	.syncWordDetected(syncWordDetected), .receiveDone(receiveDone),
	.transmitDone(transmitDone), .carrierCheckDone(carrierCheckDone),
	.carrierFound(carrierFound), .radioState(radioState),
	.carrierCheckStart(carrierCheckStart), .gpTimerOneIrq(gpTimerOneIrq),
	.gpTimerTwoIrq(gpTimerTwoIrq));

// ### test_wakeup_and_general_timers.sv
// self-checking testbench of the wake-up and general purpose timers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module test_wakeup_and_general_timers;
	logic                      clock   = 1'b0;
	logic                      arst_n  = 1'b0;
	logic                      psel    = 1'b0;
	logic                      penable = 1'b0;
	logic                      pwrite  = 1'b0;
	logic [9:0]                paddr   = 10'h000;
	logic [31:0]               pwdata  = 32'h00000000;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      pin     = 1'b0;
	logic                      sync    = 1'b0;
	logic                      rxDone  = 1'b0;
	logic                      txDone  = 1'b0;
	logic                      ccDone  = 1'b0;
	logic                      ccFound = 1'b0;
	wtg_pkg::wtg_radio_state_t radioState;
	logic                      ccStart;
	logic                      irqOne;
	logic                      irqTwo;
	int                        errors  = 0;
	int                        compares = 0;
	int                        ccStarts = 0;
	always #5 clock = ~clock;
	always @(posedge clock) begin
		if (ccStart === 1'b1) ccStarts <= ccStarts + 1;
	end
	wtg_timers dut_u (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.externalSlowClockPin(pin), .syncWordDetected(sync),
		.receiveDone(rxDone), .transmitDone(txDone),
		.carrierCheckDone(ccDone), .carrierFound(ccFound),
		.radioState(radioState), .carrierCheckStart(ccStart),
		.gpTimerOneIrq(irqOne), .gpTimerTwoIrq(irqTwo));
	////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, sn);
		compares++;
		if (sn !== ex) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	// apb master: request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] ix,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("prdata upper", 32'h0, {8'h00, rd[31:8]});
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, ix, {24'h000000, d}, r, e);
	endtask
	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
	endtask
	// one slow clock period on the pin, one rising edge for the edge detector
	task automatic tick;
		@(posedge clock);
		pin <= 1'b1;
		repeat (4) @(posedge clock);
		pin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic pulse(input int k);
		@(posedge clock);
		case (k)
			0: sync <= 1'b1;
			1: rxDone <= 1'b1;
			2: txDone <= 1'b1;
			default: ccDone <= 1'b1;
		endcase
		@(posedge clock);
		sync <= 1'b0;
		rxDone <= 1'b0;
		txDone <= 1'b0;
		ccDone <= 1'b0;
	endtask
	task automatic wstate(input wtg_pkg::wtg_radio_state_t ex, input int lim);
		int n;
		n = 0;
		while (radioState !== ex && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk("radioState", 32'(ex), 32'(radioState));
	endtask
	// divider 1, interval 2 ticks, window 1 tick, pin as timer clock
	task automatic cfg(input logic [7:0] fin, ch, ctl);
		do_reset();
		wr(wtg_pkg::IDX_FINISH_ACTIONS, fin);
		wr(wtg_pkg::IDX_CHANNEL_CHECK, ch);
		wr(wtg_pkg::IDX_WAKE_DIVIDERS, 8'h11);
		wr(wtg_pkg::IDX_WAKE_INTERVAL_HI, 8'h00);
		wr(wtg_pkg::IDX_WAKE_INTERVAL_LO, 8'h02);
		wr(wtg_pkg::IDX_WINDOW_LENGTH, 8'h02);
		wr(wtg_pkg::IDX_SLEEP_WAKE, ctl);
		wstate(wtg_pkg::RS_SLEEP, 4);
	endtask
	task automatic wake(input wtg_pkg::wtg_radio_state_t t);
		tick();
		wstate(wtg_pkg::RS_SLEEP, 0);
		tick();
		wstate(t, 12);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] ix [9];
		logic [31:0] r;
		logic e;
		ix = '{wtg_pkg::IDX_SLEEP_WAKE, wtg_pkg::IDX_WAKE_DIVIDERS,
			wtg_pkg::IDX_WAKE_INTERVAL_HI, wtg_pkg::IDX_WAKE_INTERVAL_LO,
			wtg_pkg::IDX_WINDOW_LENGTH, wtg_pkg::IDX_GP_SOURCE,
			wtg_pkg::IDX_GP_DIVIDER, wtg_pkg::IDX_GP_ONE_INTERVAL,
			wtg_pkg::IDX_GP_TWO_INTERVAL};
		do_reset();
		foreach (ix[i]) begin
			apb(1'b0, ix[i], 32'h00000000, r, e);
			chk("reset value", {24'h000000, wtg_pkg::REG_RESET}, r);
			// sleep bit left clear so no sleep command is issued
			apb(1'b1, ix[i], 32'h123456a4, r, e);
			apb(1'b0, ix[i], 32'h00000000, r, e);
			chk("readback", 32'h000000a4, r);
		end
		apb(1'b0, 8'h3f, 32'h00000000, r, e);
		chk("unmapped pslverr", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("test registers done");
	endtask
	task automatic t_rx_window;
		cfg(8'h00, 8'h00, 8'h35);
		wake(wtg_pkg::RS_RX);
		tick();
		wstate(wtg_pkg::RS_SLEEP, 12);
		wake(wtg_pkg::RS_RX);
		$display("test receive window done");
	endtask
	task automatic t_sync;
		cfg(8'h0c, 8'h00, 8'h35);
		wake(wtg_pkg::RS_RX);
		pulse(0);
		tick();
		tick();
		wstate(wtg_pkg::RS_RX, 0);
		pulse(1);
		wstate(wtg_pkg::RS_SLEEP, 4);
		wr(wtg_pkg::IDX_SERIAL_PORT, 8'h40);
		wake(wtg_pkg::RS_RX);
		pulse(0);
		tick();
		wstate(wtg_pkg::RS_SLEEP, 12);
		$display("test sync word done");
	endtask
	task automatic t_tx;
		cfg(8'h01, 8'h00, 8'h75);
		wake(wtg_pkg::RS_TX);
		tick();
		wstate(wtg_pkg::RS_SLEEP, 12);
		wake(wtg_pkg::RS_TX);
		pulse(2);
		wstate(wtg_pkg::RS_RX, 4);
		pulse(1);
		wstate(wtg_pkg::RS_OFF, 4);
		$display("test transmit done");
	endtask
	task automatic t_quick;
		int base;
		cfg(8'h00, 8'h08, 8'hb5);
		base = ccStarts;
		wake(wtg_pkg::RS_RX);
		ccFound <= 1'b0;
		pulse(3);
		wstate(wtg_pkg::RS_SLEEP, 4);
		wake(wtg_pkg::RS_RX);
		ccFound <= 1'b1;
		pulse(3);
		repeat (3) tick();
		wstate(wtg_pkg::RS_RX, 0);
		wr(wtg_pkg::IDX_SLEEP_WAKE, 8'hb5);
		wstate(wtg_pkg::RS_SLEEP, 4);
		wake(wtg_pkg::RS_RX);
		chk("check starts", 32'd3, 32'(ccStarts - base));
		$display("test quick check done");
	endtask
	task automatic gp_period(input logic two, output int n);
		int k;
		k = 0;
		while ((two ? irqTwo : irqOne) !== 1'b1 && k < 400) begin
			@(posedge clock);
			k++;
		end
		@(posedge clock);
		n = 1;
		while ((two ? irqTwo : irqOne) !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic t_gp;
		int n;
		do_reset();
		wr(wtg_pkg::IDX_GP_DIVIDER, 8'h01);
		wr(wtg_pkg::IDX_GP_ONE_INTERVAL, 8'h02);
		wr(wtg_pkg::IDX_GP_TWO_INTERVAL, 8'h01);
		wr(wtg_pkg::IDX_GP_SOURCE, 8'h33);
		gp_period(1'b0, n);
		chk("gp one period", 32'd100, 32'(n));
		gp_period(1'b1, n);
		chk("gp two period", 32'd50, 32'(n));
		$display("test general timers done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		t_regs();
		t_rx_window();
		t_sync();
		t_tx();
		t_quick();
		t_gp();
		give_verdict();
	end
	// whole run needs well under 20000 cycles
	initial begin
		#200_000;
		errors++;
		give_verdict();
	end
endmodule
